// ===== logic/rsc_defines.svh
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// ----------------------------------------------------------------
// Transition timing in crystal periods
// ----------------------------------------------------------------
`define RSC_T_CAL         16'd18739
`define RSC_T_IDLE_ACT    16'd2298
`define RSC_T_TX_TO_RX    16'd560
`define RSC_T_RX_TO_TX    16'd250
`define RSC_T_ACT_IDLE    16'd2
// ----------------------------------------------------------------
// Wake timer
// ----------------------------------------------------------------
`define RSC_WAKE_DIV      10'd750
`define RSC_WAKE_EXP_STEP 5
// ----------------------------------------------------------------
// Exit-state and calibration-policy codes
// ----------------------------------------------------------------
`define RSC_EXIT_IDLE     2'h0
`define RSC_EXIT_SYNTH    2'h1
`define RSC_EXIT_TX       2'h2
`define RSC_EXIT_RX       2'h3
`define RSC_CAL_NEVER     2'h0
`define RSC_CAL_FROM_IDLE 2'h1
`define RSC_CAL_TO_IDLE   2'h2
`define RSC_CAL_FOURTH    2'h3
// ----------------------------------------------------------------
// Clear-channel modes
// ----------------------------------------------------------------
`define RSC_CCA_ALWAYS    2'h0
`define RSC_CCA_RSSI      2'h1
`define RSC_CCA_NOPKT     2'h2

`endif

// ===== logic/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_CRYSTAL_OFF_STATE  = 9'h002,
		ST_SLEEP = 9'h004,
		ST_CAL   = 9'h008,
		ST_SETTL = 9'h010,
		ST_RX    = 9'h020,
		ST_TX    = 9'h040,
		ST_SYNTH = 9'h080,
		ST_TURN  = 9'h100
	} rsc_state_t;
endpackage : rsc_pkg
`default_nettype wire

// ===== logic/rsc_radio_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.svh"

// What this block does
// [RULE_01] Crystal automatic unless keep-running set
// [RULE_02] Crystal-off or power-down acted on only in IDLE
// [RULE_03] Chip-select low from off restarts, goes IDLE
// [RULE_04] Regulator off in SLEEP, on at chip-select
// [RULE_05] Receive/transmit via strobes or wake timer
// [RULE_06] Synth calibration per strobe or policy
// [RULE_07] Receive held until packet or timeout
// [RULE_08] After packet, receive exit setting picks state
// [RULE_09] After sending, transmit exit setting picks state
// [RULE_10] Receive strobe during transmit switches to receive
// [RULE_11] Transmit from receive only if channel clear
// [RULE_12] Force idle accepted in every state
// [RULE_13] Wake strobe enters SLEEP at chip-select release
// [RULE_14] Wake timer: SLEEP, IDLE, receive, back
// [RULE_15] Host leaves wake mode by forcing IDLE
// [RULE_16] FIFOs cleared on entering SLEEP
// [RULE_17] First event powers up, second follows later
// [RULE_18] Wake period 750 times mantissa times 2^(5e)
// [RULE_19] Host keeps sleep interval above 11.08 ms
// [RULE_20] RC calibrated while crystal runs outside SLEEP
// [RULE_21] Calibration disabled: host copies results back
// [RULE_22] Synth calibration lasts 18739 crystal periods
// [RULE_23] IDLE to active 2298 periods, plus calibration
// [RULE_24] Turnarounds 560, 250 and 2 periods
// [RULE_25] Timeout returns SLEEP if wake mode, else IDLE
module rsc_radio_ctrl #(
	parameter int unsigned MANT_W = 16
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RSTN_I,
	input  wire logic              CS_N_I,
	input  wire logic              CRYSTAL_KEEP_RUNNING_I,
	input  wire logic              CRYSTAL_OFF_STROBE_I,
	input  wire logic              POWER_DOWN_STROBE_I,
	input  wire logic              RECEIVE_STROBE_I,
	input  wire logic              TRANSMIT_STROBE_I,
	input  wire logic              SYNTH_ON_FOR_TX_STROBE_I,
	input  wire logic              CALIBRATE_STROBE_I,
	input  wire logic              FORCE_IDLE_STROBE_I,
	input  wire logic              WAKE_LISTEN_STROBE_I,
	input  wire logic [1:0]        AUTO_CAL_POLICY_I,
	input  wire logic [1:0]        RECEIVE_EXIT_STATE_I,
	input  wire logic [1:0]        TRANSMIT_EXIT_STATE_I,
	input  wire logic [1:0]        CLEAR_CHANNEL_MODE_I,
	input  wire logic              RSSI_BELOW_I,
	input  wire logic              PKT_RECEIVING_I,
	input  wire logic              RX_PKT_OK_I,
	input  wire logic              RX_TIMEOUT_I,
	input  wire logic              TX_PKT_DONE_I,
	input  wire logic [MANT_W-1:0] WAKE_PERIOD_MANTISSA_I,
	input  wire logic [1:0]        WAKE_PERIOD_EXPONENT_I,
	input  wire logic [15:0]       SECOND_EVENT_TIMEOUT_I,
	input  wire logic              RC_CALIB_ENABLE_I,
	output var  rsc_pkg::rsc_state_t STATE_O,
	output logic                   CRYSTAL_OSC_ON_O,
	output logic                   REGULATOR_ON_O,
	output logic                   FIFO_FLUSH_O,
	output logic                   WAKE_MODE_O,
	output logic                   RC_CALIB_ACTIVE_O,
	output logic                   FIRST_EVENT_O,
	output logic                   SECOND_EVENT_O
);
	import rsc_pkg::*;

	// ----------------------------------------------------------------
	// State, pending destination and counters
	// ----------------------------------------------------------------
	rsc_state_t       state_q;
	rsc_state_t       dest_q;
	rsc_state_t       sleep_tgt_q;
	logic             cs_arm_q;
	logic             wor_q;
	logic [15:0]      tcnt_q;
	logic             cal_then_q;
	logic [1:0]       cal4_q;
	logic             osc_q;
	logic             fifo_q;
	logic [9:0]       div_q;
	logic [MANT_W+14:0] wcnt_q;
	logic [15:0]      ev1_q;
	logic             ev1_run_q;
	logic             wake_go_q;
	logic             cal_idle;
	logic             ev0_p;
	logic             cca_ok;
	logic             tmr_done;
	logic [MANT_W+14:0] wlimit;

	assign tmr_done = (tcnt_q == 16'h0000);
	assign cal_idle = (AUTO_CAL_POLICY_I == `RSC_CAL_TO_IDLE)
		|| (AUTO_CAL_POLICY_I == `RSC_CAL_FOURTH && cal4_q == 2'h3);
	assign wlimit = (MANT_W+15)'(WAKE_PERIOD_MANTISSA_I)
		<< (`RSC_WAKE_EXP_STEP * WAKE_PERIOD_EXPONENT_I);

	always_comb begin
		unique case (CLEAR_CHANNEL_MODE_I)
			`RSC_CCA_ALWAYS: cca_ok = 1'b1;
			`RSC_CCA_RSSI:   cca_ok = RSSI_BELOW_I;
			`RSC_CCA_NOPKT:  cca_ok = !PKT_RECEIVING_I;
			default:         cca_ok = RSSI_BELOW_I && !PKT_RECEIVING_I;
		endcase
	end

	function automatic logic cal_from_idle(input logic [1:0] p);
		return p == `RSC_CAL_FROM_IDLE;
	endfunction : cal_from_idle

	// ----------------------------------------------------------------
	// Main state machine
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= ST_IDLE;
			dest_q <= ST_IDLE;
			sleep_tgt_q <= ST_IDLE;
			cs_arm_q <= 1'b0;
			wor_q <= 1'b0;
			tcnt_q <= 16'h0000;
			cal_then_q <= 1'b0;
			cal4_q <= 2'h0;
			wake_go_q <= 1'b0;
		end else begin
			wake_go_q <= 1'b0;
			if (tcnt_q != 16'h0000)
				tcnt_q <= tcnt_q - 16'h0001;
			// [RULE_12] Force idle always
			// [RULE_15] Leaves wake mode
			if (FORCE_IDLE_STROBE_I) begin
				state_q <= ST_IDLE;
				cs_arm_q <= 1'b0;
				wor_q <= 1'b0;
				cal_then_q <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						if (cs_arm_q && CS_N_I) begin
							// [RULE_02] Enter off state
							// [RULE_13] Sleep on release
							state_q <= sleep_tgt_q;
							cs_arm_q <= 1'b0;
						end else if (CRYSTAL_OFF_STROBE_I
							&& !CRYSTAL_KEEP_RUNNING_I) begin
							// [RULE_02] Only from idle
							sleep_tgt_q <= ST_CRYSTAL_OFF_STATE;
							cs_arm_q <= 1'b1;
						end else if (POWER_DOWN_STROBE_I) begin
							sleep_tgt_q <= ST_SLEEP;
							cs_arm_q <= 1'b1;
						end else if (WAKE_LISTEN_STROBE_I) begin
							sleep_tgt_q <= ST_SLEEP;
							cs_arm_q <= 1'b1;
							wor_q <= 1'b1;
						end else if (CALIBRATE_STROBE_I) begin
							// [RULE_22] Fixed calibration time
							state_q <= ST_CAL;
							dest_q <= ST_IDLE;
							tcnt_q <= `RSC_T_CAL;
						end else if (RECEIVE_STROBE_I
							|| TRANSMIT_STROBE_I
							|| SYNTH_ON_FOR_TX_STROBE_I
							|| (wor_q && (ev0_p || wake_go_q))) begin
							// [RULE_05] Activate on strobe or timer
							// [RULE_23] Idle to active timing
							dest_q <= (TRANSMIT_STROBE_I) ? ST_TX :
								(SYNTH_ON_FOR_TX_STROBE_I) ? ST_SYNTH : ST_RX;
							if (cal_from_idle(AUTO_CAL_POLICY_I)) begin
								// [RULE_06] Calibrate from idle
								state_q <= ST_CAL;
								tcnt_q <= `RSC_T_CAL;
								cal_then_q <= 1'b1;
							end else begin
								state_q <= ST_SETTL;
								tcnt_q <= `RSC_T_IDLE_ACT;
							end
						end
					end
					ST_CRYSTAL_OFF_STATE, ST_SLEEP: begin
						// [RULE_03] Wake by chip-select
						// [RULE_14] Timer wakes to idle
						if (!CS_N_I) begin
							state_q <= ST_IDLE;
							wor_q <= 1'b0;
						end else if (state_q == ST_SLEEP && wor_q
							&& ev0_p) begin
							state_q <= ST_IDLE;
							wake_go_q <= 1'b1;
						end
					end
					ST_CAL: begin
						if (tmr_done) begin
							if (cal_then_q) begin
								state_q <= ST_SETTL;
								tcnt_q <= `RSC_T_IDLE_ACT;
								cal_then_q <= 1'b0;
							end else
								state_q <= ST_IDLE;
						end
					end
					ST_SETTL, ST_TURN: begin
						if (tmr_done)
							state_q <= dest_q;
					end
					ST_RX: begin
						// [RULE_07] Hold receive
						if (RX_PKT_OK_I) begin
							// [RULE_08] Receive exit
							unique case (RECEIVE_EXIT_STATE_I)
								`RSC_EXIT_IDLE: begin
									state_q <= ST_TURN;
									dest_q <= ST_IDLE;
									tcnt_q <= `RSC_T_ACT_IDLE;
									if (cal_idle) begin
										// [RULE_06] Calibrate to idle
										state_q <= ST_CAL;
										tcnt_q <= `RSC_T_CAL;
									end
									cal4_q <= cal4_q + 2'h1;
								end
								`RSC_EXIT_SYNTH: state_q <= ST_SYNTH;
								`RSC_EXIT_TX: begin
									state_q <= ST_TURN;
									dest_q <= ST_TX;
									tcnt_q <= `RSC_T_RX_TO_TX;
								end
								default: state_q <= ST_RX;
							endcase
						end else if (RX_TIMEOUT_I) begin
							// [RULE_25] Timeout exit
							state_q <= wor_q ? ST_SLEEP : ST_IDLE;
						end else if ((TRANSMIT_STROBE_I
							|| SYNTH_ON_FOR_TX_STROBE_I) && cca_ok) begin
							// [RULE_11] Clear channel check
							state_q <= ST_TURN;
							dest_q <= TRANSMIT_STROBE_I ? ST_TX : ST_SYNTH;
							tcnt_q <= `RSC_T_RX_TO_TX;
						end
					end
					ST_TX: begin
						if (RECEIVE_STROBE_I) begin
							// [RULE_10] Abort transmit
							// [RULE_24] Turnaround timing
							state_q <= ST_TURN;
							dest_q <= ST_RX;
							tcnt_q <= `RSC_T_TX_TO_RX;
						end else if (TX_PKT_DONE_I) begin
							// [RULE_09] Transmit exit
							state_q <= ST_TURN;
							tcnt_q <= `RSC_T_ACT_IDLE;
							unique case (TRANSMIT_EXIT_STATE_I)
								`RSC_EXIT_IDLE: begin
									dest_q <= ST_IDLE;
									// [RULE_06] Calibrate to idle
									if (cal_idle) begin
										state_q <= ST_CAL;
										tcnt_q <= `RSC_T_CAL;
									end
									cal4_q <= cal4_q + 2'h1;
								end
								`RSC_EXIT_SYNTH: dest_q <= ST_SYNTH;
								`RSC_EXIT_TX:    dest_q <= ST_TX;
								default: begin
									dest_q <= ST_RX;
									tcnt_q <= `RSC_T_TX_TO_RX;
								end
							endcase
						end
					end
					ST_SYNTH: begin
						if (TRANSMIT_STROBE_I) begin
							state_q <= ST_TX;
						end else if (RECEIVE_STROBE_I) begin
							state_q <= ST_TURN;
							dest_q <= ST_RX;
							tcnt_q <= `RSC_T_TX_TO_RX;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Crystal, regulator and FIFO control
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			osc_q <= 1'b1;
			fifo_q <= 1'b0;
		end else begin
			// [RULE_01] Keep-running overrides
			// [RULE_17] First event starts crystal
			osc_q <= CRYSTAL_KEEP_RUNNING_I
				|| !(state_q == ST_CRYSTAL_OFF_STATE || state_q == ST_SLEEP)
				|| !CS_N_I || (wor_q && ev0_p);
			// [RULE_16] Flush on sleep entry
			fifo_q <= !FORCE_IDLE_STROBE_I && ((state_q == ST_IDLE
				&& cs_arm_q && CS_N_I && sleep_tgt_q == ST_SLEEP)
				|| (state_q == ST_RX && RX_TIMEOUT_I && !RX_PKT_OK_I
				&& wor_q));
		end
	end

	// [RULE_04] Regulator follows sleep
	assign REGULATOR_ON_O = (state_q != ST_SLEEP);
	assign CRYSTAL_OSC_ON_O = osc_q;
	assign FIFO_FLUSH_O = fifo_q;
	assign STATE_O = state_q;
	assign WAKE_MODE_O = wor_q;
	// [RULE_20] RC calibration window
	// [RULE_21] Disabled holds host values
	assign RC_CALIB_ACTIVE_O = RC_CALIB_ENABLE_I && osc_q
		&& (state_q != ST_SLEEP);

	// ----------------------------------------------------------------
	// Wake timer
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			div_q <= 10'h000;
			wcnt_q <= '0;
			ev0_p <= 1'b0;
			ev1_q <= 16'h0000;
			ev1_run_q <= 1'b0;
		end else begin
			ev0_p <= 1'b0;
			// [RULE_18] Period of first event
			if (!wor_q) begin
				div_q <= 10'h000;
				wcnt_q <= '0;
			end else if (div_q == `RSC_WAKE_DIV - 10'd1) begin
				div_q <= 10'h000;
				if (wcnt_q + 1'b1 >= wlimit) begin
					wcnt_q <= '0;
					ev0_p <= 1'b1;
				end else
					wcnt_q <= wcnt_q + 1'b1;
			end else
				div_q <= div_q + 10'd1;
			// [RULE_17] Second event timeout
			if (ev0_p) begin
				ev1_q <= SECOND_EVENT_TIMEOUT_I;
				ev1_run_q <= 1'b1;
			end else if (ev1_run_q) begin
				if (ev1_q == 16'h0000)
					ev1_run_q <= 1'b0;
				else
					ev1_q <= ev1_q - 16'h0001;
			end
		end
	end

	assign FIRST_EVENT_O = ev0_p;
	assign SECOND_EVENT_O = ev1_run_q && (ev1_q == 16'h0000);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// [RULE_12] Force idle
	property p_idle;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		FORCE_IDLE_STROBE_I |=> state_q == ST_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle missed"); // [RULE_12]
	// [RULE_22] Calibration length
	property p_cal;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		($rose(state_q == ST_CAL) && !FORCE_IDLE_STROBE_I)
			|-> tcnt_q == `RSC_T_CAL;
	endproperty
	a_cal: assert property (p_cal) else $error("cal length"); // [RULE_22]
	// [RULE_04] Regulator
	property p_reg;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(state_q == ST_SLEEP && !CS_N_I && !FORCE_IDLE_STROBE_I)
			|-> !REGULATOR_ON_O ##1 (REGULATOR_ON_O && state_q == ST_IDLE);
	endproperty
	a_reg: assert property (p_reg) else $error("regulator on"); // [RULE_04]
	// [RULE_16] Flush on sleep entry
	property p_flush;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		$rose(state_q == ST_SLEEP) |-> FIFO_FLUSH_O;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush"); // [RULE_16]
	// [RULE_01] Crystal forced
	property p_osc;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		CRYSTAL_KEEP_RUNNING_I |=> CRYSTAL_OSC_ON_O;
	endproperty
	a_osc: assert property (p_osc) else $error("crystal off"); // [RULE_01]
	// [RULE_11] Busy channel
	property p_cca;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(state_q == ST_RX && TRANSMIT_STROBE_I && !cca_ok && !RX_PKT_OK_I
		&& !RX_TIMEOUT_I && !FORCE_IDLE_STROBE_I) |=> state_q == ST_RX;
	endproperty
	a_cca: assert property (p_cca) else $error("cca ignored"); // [RULE_11]
	// [RULE_25] Timeout exit
	property p_to;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(state_q == ST_RX && RX_TIMEOUT_I && !RX_PKT_OK_I
		&& !FORCE_IDLE_STROBE_I && wor_q) |=> state_q == ST_SLEEP;
	endproperty
	a_to: assert property (p_to) else $error("timeout exit"); // [RULE_25]
	// [RULE_24] Transmit to receive
	property p_turn;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(state_q == ST_TX && RECEIVE_STROBE_I && !FORCE_IDLE_STROBE_I)
			|=> tcnt_q == `RSC_T_TX_TO_RX;
	endproperty
	a_turn: assert property (p_turn) else $error("turn time"); // [RULE_24]
	// [RULE_03] Chip-select wake
	property p_wake;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		(state_q == ST_CRYSTAL_OFF_STATE && !CS_N_I && !FORCE_IDLE_STROBE_I)
			|=> state_q == ST_IDLE ##1 CRYSTAL_OSC_ON_O;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // [RULE_03]
	c_rx: cover property (@(posedge SYS_CLK_I) state_q == ST_RX);
	c_tx: cover property (@(posedge SYS_CLK_I) state_q == ST_TX);
	c_ev: cover property (@(posedge SYS_CLK_I) ev0_p);
	c_wake: cover property (@(posedge SYS_CLK_I) wake_go_q);
endmodule : rsc_radio_ctrl
`default_nettype wire

// ===== dv/rsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host model issuing command strobes
// ----------------------------------------------------------------
module rsc_host_model (
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	output logic            cs_n_o,
	output logic            rc_en_o,
	output logic [7:0]      strb_o
);
	task automatic init;
		cs_n_o <= 1'b1;
		rc_en_o <= 1'b1;
		strb_o <= 8'h00;
	endtask : init

	task automatic rc(input logic v);
		@(posedge clk_i);
		rc_en_o <= v;
	endtask : rc

	task automatic sel;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 0; i < 100 && ready_i !== 1'b1; i++)
			@(posedge clk_i);
		@(posedge clk_i);
	endtask : sel

	task automatic rel;
		@(posedge clk_i);
		cs_n_o <= 1'b1;
	endtask : rel

	task automatic strobe(input int k);
		@(posedge clk_i);
		strb_o <= 8'h01 << k;
		@(posedge clk_i);
		strb_o <= 8'h00;
	endtask : strobe
endmodule : rsc_host_model
`default_nettype wire

// ===== dv/rsc_radio_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench for the radio state controller
// ----------------------------------------------------------------
module rsc_radio_ctrl_tb_top;
	import rsc_pkg::*;
	logic        clk, rstn, cs_n, rc_en, xo, reg_on, flush, wake, rcal;
	logic        ev0, ev1, sec;
	logic        keep;
	logic        rssi;
	logic        pkt;
	logic [7:0]  strb;
	logic [2:0]  dp;
	logic [1:0]  pol;
	logic [1:0]  rxe;
	logic [1:0]  txe;
	logic [1:0]  cca;
	logic [15:0] mant;
	logic [1:0]  expo;
	logic [15:0] ev1t;
	int          nfl;
	int          ncal = 0;
	rsc_state_t  st;
	rsc_state_t  xexp [4] = '{ST_IDLE, ST_SYNTH, ST_TX, ST_RX};
	rsc_state_t  cexp [4] = '{ST_TX, ST_SYNTH, ST_RX, ST_RX};
	int          fails = 0;
	int          checks = 0;
	int          n = 0;
	int          gap = 0;
	int          since = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	rsc_radio_ctrl uut (.SYS_CLK_I(clk), .RSTN_I(rstn), .CS_N_I(cs_n),
		.CRYSTAL_KEEP_RUNNING_I(keep), .CRYSTAL_OFF_STROBE_I(strb[0]),
		.POWER_DOWN_STROBE_I(strb[1]), .RECEIVE_STROBE_I(strb[2]),
		.TRANSMIT_STROBE_I(strb[3]), .SYNTH_ON_FOR_TX_STROBE_I(strb[4]),
		.CALIBRATE_STROBE_I(strb[5]), .FORCE_IDLE_STROBE_I(strb[6]),
		.WAKE_LISTEN_STROBE_I(strb[7]), .AUTO_CAL_POLICY_I(pol),
		.RECEIVE_EXIT_STATE_I(rxe), .TRANSMIT_EXIT_STATE_I(txe),
		.CLEAR_CHANNEL_MODE_I(cca), .RSSI_BELOW_I(rssi),
		.PKT_RECEIVING_I(pkt), .RX_PKT_OK_I(dp[0]), .RX_TIMEOUT_I(dp[1]),
		.TX_PKT_DONE_I(dp[2]), .WAKE_PERIOD_MANTISSA_I(mant),
		.WAKE_PERIOD_EXPONENT_I(expo), .SECOND_EVENT_TIMEOUT_I(ev1t),
		.RC_CALIB_ENABLE_I(rc_en), .STATE_O(st), .CRYSTAL_OSC_ON_O(xo),
		.REGULATOR_ON_O(reg_on), .FIFO_FLUSH_O(flush), .WAKE_MODE_O(wake),
		.RC_CALIB_ACTIVE_O(rcal), .FIRST_EVENT_O(ev0),
		.SECOND_EVENT_O(ev1));

	rsc_host_model host (.clk_i(clk), .ready_i(xo), .cs_n_o(cs_n),
		.rc_en_o(rc_en), .strb_o(strb));

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sec <= 1'b0;
			nfl <= 0;
		end else begin
			since <= ev0 ? 1 : since + 1;
			if (ev0)
				gap <= since;
			if (ev1)
				sec <= 1'b1;
			if (flush)
				nfl <= nfl + 1;
		end
	end

	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic rng(input string nm, input int v, lo, hi);
		check(nm, {15'h0000, v >= lo && v <= hi}, 16'h0001);
	endtask : rng

	task automatic wait_st(input rsc_state_t s, input int lim);
		n = 0;
		#1;
		while (st !== s && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_st

	task automatic dpulse(input int k);
		@(posedge clk);
		dp <= 3'h1 << k;
		@(posedge clk);
		dp <= 3'h0;
	endtask : dpulse

	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (99000) @(posedge clk);
		fails++;
		wrap_up();
	end

	initial begin
		rstn <= 1'b0;
		host.init();
		keep <= 1'b0;
		rssi <= 1'b1;
		pkt <= 1'b1;
		dp <= 3'h0;
		pol <= 2'h0;
		rxe <= 2'h0;
		txe <= 2'h0;
		cca <= 2'h0;
		// Short interval, early event not modelled.
		mant <= 16'h0004;
		expo <= 2'h0;
		ev1t <= 16'h0001;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		wait_st(ST_IDLE, 2);
		check("rst", {st == ST_IDLE, xo, reg_on}, 16'h7);
		host.sel();
		keep <= 1'b1;
		host.strobe(0);
		host.rel();
		wait_st(ST_CRYSTAL_OFF_STATE, 4);
		check("keep crystal_off_state", st, ST_IDLE);
		host.sel();
		host.strobe(1);
		host.rel();
		wait_st(ST_SLEEP, 5);
		step();
		check("keep sleep", {xo, reg_on, nfl == 1}, 16'h5);
		check("fifo flush", 16'(nfl), 16'h1);
		host.sel();
		keep <= 1'b0;
		wait_st(ST_IDLE, 50);
		check("reg back", reg_on, 16'h1);
		host.strobe(0);
		host.rel();
		wait_st(ST_CRYSTAL_OFF_STATE, 5);
		step();
		check("crystal_off_state", {st == ST_CRYSTAL_OFF_STATE, xo}, 16'h2);
		host.sel();
		wait_st(ST_IDLE, 50);
		check("wake up", {st == ST_IDLE, xo}, 16'h3);
		check("rc_calib_enable", rcal, 16'h1);
		host.rc(1'b0);
		step();
		check("rc off", rcal, 16'h0);
		host.rc(1'b1);
		host.strobe(2);
		wait_st(ST_RX, 3000);
		rng("idle to rx", n, 2297, 2302);
		host.strobe(1);
		wait_st(ST_SLEEP, 4);
		check("pwd in rx", st, ST_RX);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk) cca <= 2'(m);
			host.strobe(m == 1 ? 4 : 3);
			wait_st(cexp[m], 400);
			check("cca", st, cexp[m]);
			if (m == 0)
				rng("rx to tx", n, 249, 253);
			host.strobe(2);
			wait_st(ST_RX, 3000);
			if (m == 0)
				rng("tx to rx", n, 559, 563);
		end
		@(posedge clk) cca <= 2'h0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			rxe <= 2'(k);
			txe <= 2'(k);
			dpulse(0);
			wait_st(xexp[k], 3000);
			check("rx exit", st, xexp[k]);
			host.strobe(6);
			wait_st(ST_IDLE, 5);
			rng("force idle", n, 0, 4);
			host.strobe(3);
			wait_st(ST_TX, 3000);
			dpulse(2);
			wait_st(xexp[k], 3000);
			check("tx exit", st, xexp[k]);
			host.strobe(6);
			host.strobe(2);
			wait_st(ST_RX, 3000);
			check("rx held", st, ST_RX);
		end
		host.strobe(6);
		host.strobe(5);
		wait_st(ST_CAL, 3);
		wait_st(ST_IDLE, 20000);
		rng("manual cal", n, 18736, 18742);
		@(posedge clk) pol <= 2'h1;
		host.strobe(2);
		wait_st(ST_RX, 22000);
		rng("cal to rx", n, 21030, 21045);
		@(posedge clk) pol <= 2'h2;
		host.strobe(6);
		wait_st(ST_IDLE, 5);
		rng("idle no cal", n, 0, 4);
		host.strobe(2);
		wait_st(ST_RX, 3000);
		@(posedge clk) rxe <= 2'h0;
		dpulse(0);
		wait_st(ST_CAL, 10);
		check("auto cal", st, ST_CAL);
		host.strobe(6);
		wait_st(ST_IDLE, 5);
		@(posedge clk) txe <= 2'h0;
		host.strobe(3);
		wait_st(ST_TX, 3000);
		dpulse(2);
		wait_st(ST_CAL, 10);
		check("tx auto cal", st, ST_CAL);
		host.strobe(6);
		wait_st(ST_IDLE, 5);
		@(posedge clk) pol <= 2'h3;
		for (int j = 0; j < 4; j++) begin
			host.strobe(2);
			wait_st(ST_RX, 3000);
			dpulse(0);
			wait_st(ST_CAL, 4);
			if (st == ST_CAL) begin
				ncal++;
				host.strobe(6);
			end
			wait_st(ST_IDLE, 10);
		end
		check("every fourth", 16'(ncal), 16'h1);
		@(posedge clk) pol <= 2'h0;
		host.strobe(7);
		host.rel();
		wait_st(ST_SLEEP, 5);
		check("wor sleep", {st == ST_SLEEP, wake, rcal}, 16'h6);
		wait_st(ST_IDLE, 4000);
		check("ev0 power", {reg_on, xo}, 16'h3);
		check("wor flush", 16'(nfl), 16'h2);
		wait_st(ST_RX, 3000);
		check("wor rx", st, ST_RX);
		dpulse(1);
		wait_st(ST_SLEEP, 10);
		check("timeout", st, ST_SLEEP);
		wait_st(ST_IDLE, 4000);
		check("rx off flush", 16'(nfl), 16'h3);
		repeat (3) @(posedge clk);
		rng("ev0 gap", gap, 2998, 3002);
		check("ev1 seen", sec, 16'h1);
		host.sel();
		host.strobe(6);
		wait_st(ST_RX, 3);
		check("wor exit", {st == ST_IDLE, wake}, 16'h2);
		wrap_up();
	end
endmodule : rsc_radio_ctrl_tb_top
`default_nettype wire
